// ### dtc_pkg.sv
package dtc_pkg;
    // --------------------------------------------------------------
    // clock and timing
    // --------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int INTEG_US = 60_000;
    localparam int CONV_US = 125_000;
    localparam int SETTLE_US = (CONV_US - 2 * INTEG_US) / 2;
    localparam int AUTO_BASE_US = 16_000_000;
    localparam int INTEG_CYC = INTEG_US * CYC_PER_US;
    localparam int SETTLE_CYC = SETTLE_US * CYC_PER_US;
    localparam int AUTO_BASE_CYC = AUTO_BASE_US * CYC_PER_US;
    localparam int TMR_W = 32;
    localparam int SYNC_STAGES = 2;

    // --------------------------------------------------------------
    // data formats
    // --------------------------------------------------------------
    localparam int TEMP_W = 8;
    localparam int RAW_W = TEMP_W + 1;
    localparam int RATE_W = 3;
    localparam int ADDR_W = 2;
    localparam int ALM_W = 4;
    localparam int ALM_RHI = 0;
    localparam int ALM_RLO = 1;
    localparam int ALM_LHI = 2;
    localparam int ALM_LLO = 3;
    localparam logic [RAW_W:0] HALF_LSB = 10'h001;
    localparam logic [TEMP_W-1:0] TEMP_MAX = 8'h7f;
    localparam logic [TEMP_W-1:0] TEMP_RST = 8'h00;
    localparam logic [TMR_W-1:0] TMR_ONE = 32'h0000_0001;
    localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
    localparam logic [1:0] CAP_DONE = 2'h2;

    // --------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        DTC_IDLE = 3'h0,
        DTC_SET_R = 3'h1,
        DTC_INT_R = 3'h2,
        DTC_SET_L = 3'h3,
        DTC_INT_L = 3'h4,
        DTC_LATCH = 3'h5,
        DTC_CMP = 3'h6
    } dtc_state_e;
endpackage

// ### dtc_cmp_if.sv
`timescale 1ns/1ps
interface dtc_cmp_if;
    import dtc_pkg::*;
    logic update;
    logic signed [TEMP_W-1:0] temp;
    logic signed [TEMP_W-1:0] thr_hi;
    logic signed [TEMP_W-1:0] thr_lo;
    logic over;
    logic under;
    modport ctl (output update, output temp, output thr_hi, output thr_lo, input over, input under);
    modport cmp (input update, input temp, input thr_hi, input thr_lo, output over, output under);
endinterface

// ### dtc_cmp.sv
`timescale 1ns/1ps
module dtc_cmp
    import dtc_pkg::*;
(
    dtc_cmp_if.cmp c
);
    // --------------------------------------------------------------
    // signed window compare, valid only on the update pulse
    // --------------------------------------------------------------
    always_comb begin
        c.over = c.update && (c.temp > c.thr_hi);
        c.under = c.update && (c.temp < c.thr_lo);
    end
endmodule

// ### dtc_sync.sv
`timescale 1ns/1ps
module dtc_sync
    import dtc_pkg::*;
#(
    parameter int W = 1
) (
    // clock
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // --------------------------------------------------------------
    // two-stage synchroniser; first stage feeds only the second
    // --------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### dtc_top.sv
`timescale 1ns/1ps
module dtc_top
    import dtc_pkg::*;
#(
    parameter int INTEG_CYCLES = INTEG_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int AUTO_CYCLES = AUTO_BASE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // pins
    input wire logic addr_select_low_pin,
    input wire logic addr_select_high_pin,
    input wire logic hw_sleep_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic alert_out,
    output logic alert_oe_n,
    // serial target logic side
    input wire logic sda_pull,
    output logic sda_sampled,
    output logic [ADDR_W-1:0] bus_addr,
    output logic addr_valid,
    // control from configuration
    input wire logic sw_stop,
    input wire logic [RATE_W-1:0] rate_sel,
    input wire logic oneshot_req,
    input wire logic alarm_clr,
    input wire logic signed [TEMP_W-1:0] thr_remote_hi,
    input wire logic signed [TEMP_W-1:0] thr_remote_lo,
    input wire logic signed [TEMP_W-1:0] thr_local_hi,
    input wire logic signed [TEMP_W-1:0] thr_local_lo,
    // analog front end
    output logic fe_local,
    output logic fe_integrate,
    input wire logic signed [RAW_W-1:0] fe_code,
    // status
    output logic busy,
    output logic [ALM_W-1:0] alarm,
    output logic signed [TEMP_W-1:0] temp_remote,
    output logic signed [TEMP_W-1:0] temp_local
);
    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [ADDR_W-1:0] addr_s;
    logic sleep_n_s;
    logic sda_s;

    dtc_sync #(.W(ADDR_W)) u_sync_addr (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .d({addr_select_high_pin, addr_select_low_pin}),
        .q(addr_s)
    );
    dtc_sync #(.W(2)) u_sync_pins (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .d({hw_sleep_n, sda_in}),
        .q({sleep_n_s, sda_s})
    );

    // --------------------------------------------------------------
    // address capture
    // --------------------------------------------------------------
    // sync chain needs two enabled edges before addr_s is meaningful
    logic [1:0] cap_cnt;
    logic [1:0] next_cap_cnt;
    logic [ADDR_W-1:0] next_bus_addr;
    logic next_addr_valid;

    always_comb begin
        next_cap_cnt = cap_cnt;
        next_bus_addr = bus_addr;
        next_addr_valid = addr_valid;
        if (!addr_valid) begin
            if (cap_cnt == CAP_DONE) begin
                next_bus_addr = addr_s;
                next_addr_valid = 1'b1;
            end else begin
                next_cap_cnt = cap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt <= 2'h0;
            bus_addr <= '0;
            addr_valid <= 1'b0;
        end else if (ce) begin
            cap_cnt <= next_cap_cnt;
            bus_addr <= next_bus_addr;
            addr_valid <= next_addr_valid;
        end
    end

    // --------------------------------------------------------------
    // conversion sequencer
    // --------------------------------------------------------------
    dtc_state_e state;
    dtc_state_e next_state;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    logic [TMR_W-1:0] auto_tmr;
    logic [TMR_W-1:0] next_auto_tmr;
    logic signed [RAW_W-1:0] raw_r;
    logic signed [RAW_W-1:0] raw_l;
    logic signed [RAW_W-1:0] next_raw_r;
    logic signed [RAW_W-1:0] next_raw_l;
    logic signed [TEMP_W-1:0] next_temp_remote;
    logic signed [TEMP_W-1:0] next_temp_local;
    logic sw_stop_q;
    logic start;
    logic abort;
    logic [TMR_W-1:0] auto_reload;

    // round to nearest degree, saturating at the top of the range
    function automatic logic [TEMP_W-1:0] dtc_round(input logic [RAW_W-1:0] raw);
        logic [RAW_W:0] sum;
        sum = {raw[RAW_W-1], raw} + HALF_LSB;
        if (sum[RAW_W] != sum[RAW_W-1]) begin
            dtc_round = TEMP_MAX;
        end else begin
            dtc_round = sum[TEMP_W:1];
        end
    endfunction

    assign auto_reload = TMR_W'(AUTO_CYCLES) >> rate_sel;

    always_comb begin
        // sleep pin blocks every start; one-shot still runs under software stop
        start = (state == DTC_IDLE) && sleep_n_s
                && (oneshot_req || (!sw_stop && auto_tmr == TMR_ZERO));
        abort = (state != DTC_IDLE) && (!sleep_n_s || (sw_stop && !sw_stop_q));
        next_state = state;
        next_tmr = tmr;
        next_raw_r = raw_r;
        next_raw_l = raw_l;
        next_temp_remote = temp_remote;
        next_temp_local = temp_local;
        next_auto_tmr = auto_tmr;
        if (sw_stop || !sleep_n_s) begin
            next_auto_tmr = auto_reload;
        end else if (start) begin
            next_auto_tmr = auto_reload - TMR_ONE;
        end else if (auto_tmr != TMR_ZERO) begin
            next_auto_tmr = auto_tmr - TMR_ONE;
        end
        if (abort) begin
            next_state = DTC_IDLE;
            next_tmr = TMR_ZERO;
        end else begin
            unique case (state)
                DTC_IDLE: begin
                    if (start) begin
                        next_state = DTC_SET_R;
                        next_tmr = TMR_W'(SETTLE_CYCLES) - TMR_ONE;
                    end
                end
                DTC_SET_R: begin
                    if (tmr == TMR_ZERO) begin
                        next_state = DTC_INT_R;
                        next_tmr = TMR_W'(INTEG_CYCLES) - TMR_ONE;
                    end else begin
                        next_tmr = tmr - TMR_ONE;
                    end
                end
                DTC_INT_R: begin
                    if (tmr == TMR_ZERO) begin
                        next_raw_r = fe_code;
                        next_state = DTC_SET_L;
                        next_tmr = TMR_W'(SETTLE_CYCLES) - TMR_ONE;
                    end else begin
                        next_tmr = tmr - TMR_ONE;
                    end
                end
                DTC_SET_L: begin
                    if (tmr == TMR_ZERO) begin
                        next_state = DTC_INT_L;
                        next_tmr = TMR_W'(INTEG_CYCLES) - TMR_ONE;
                    end else begin
                        next_tmr = tmr - TMR_ONE;
                    end
                end
                DTC_INT_L: begin
                    if (tmr == TMR_ZERO) begin
                        next_raw_l = fe_code;
                        next_state = DTC_LATCH;
                    end else begin
                        next_tmr = tmr - TMR_ONE;
                    end
                end
                DTC_LATCH: begin
                    // results change only here, so readers never see a half update
                    next_temp_remote = dtc_round(raw_r);
                    next_temp_local = dtc_round(raw_l);
                    next_state = DTC_CMP;
                end
                DTC_CMP: begin
                    next_state = DTC_IDLE;
                end
                default: begin
                    next_state = DTC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DTC_IDLE;
            tmr <= TMR_ZERO;
            auto_tmr <= TMR_ZERO;
            raw_r <= '0;
            raw_l <= '0;
            temp_remote <= TEMP_RST;
            temp_local <= TEMP_RST;
            sw_stop_q <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            tmr <= next_tmr;
            auto_tmr <= next_auto_tmr;
            raw_r <= next_raw_r;
            raw_l <= next_raw_l;
            temp_remote <= next_temp_remote;
            temp_local <= next_temp_local;
            sw_stop_q <= sw_stop;
        end
    end

    assign busy = (state != DTC_IDLE);
    assign fe_local = (state == DTC_SET_L) || (state == DTC_INT_L);
    assign fe_integrate = (state == DTC_INT_R) || (state == DTC_INT_L);

    // --------------------------------------------------------------
    // threshold compare and alarm flags
    // --------------------------------------------------------------
    dtc_cmp_if cif_r ();
    dtc_cmp_if cif_l ();
    logic [ALM_W-1:0] next_alarm;
    logic [ALM_W-1:0] alm_set;
    logic next_alert_oe_n;
    logic next_sda_oe_n;

    assign cif_r.update = (state == DTC_CMP);
    assign cif_r.temp = temp_remote;
    assign cif_r.thr_hi = thr_remote_hi;
    assign cif_r.thr_lo = thr_remote_lo;
    assign cif_l.update = (state == DTC_CMP);
    assign cif_l.temp = temp_local;
    assign cif_l.thr_hi = thr_local_hi;
    assign cif_l.thr_lo = thr_local_lo;

    dtc_cmp u_cmp_r (.c(cif_r.cmp));
    dtc_cmp u_cmp_l (.c(cif_l.cmp));

    always_comb begin
        alm_set = '0;
        alm_set[ALM_RHI] = cif_r.over;
        alm_set[ALM_RLO] = cif_r.under;
        alm_set[ALM_LHI] = cif_l.over;
        alm_set[ALM_LLO] = cif_l.under;
        // a new event wins over a clear in the same cycle
        next_alarm = (alarm & ~{ALM_W{alarm_clr}}) | alm_set;
        next_alert_oe_n = ~(|next_alarm);
        next_sda_oe_n = ~sda_pull;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm <= '0;
            alert_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else if (ce) begin
            alarm <= next_alarm;
            alert_oe_n <= next_alert_oe_n;
            sda_oe_n <= next_sda_oe_n;
        end
    end

    // open-drain pins only ever drive low
    assign alert_out = 1'b0;
    assign sda_out = 1'b0;
    // pure level path, no bus-clock timeouts: stays valid at any slow rate
    assign sda_sampled = sda_s;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking dtc_cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_ADDR_HOLD: assert property (addr_valid |=> addr_valid && $stable(bus_addr))
        else $error("captured address changed");
    AST_SLEEP_NO_START: assert property (ce && state == DTC_IDLE && !sleep_n_s |=> state == DTC_IDLE)
        else $error("conversion started in hardware sleep");
    AST_HOLD_HW_SLEEP_N: assert property (!sleep_n_s |=> $stable(temp_remote) && $stable(temp_local))
        else $error("results changed in standby");
    AST_BOTH_CH: assert property (ce && state == DTC_INT_R && tmr == TMR_ZERO && !abort
        |=> state == DTC_SET_L && fe_local)
        else $error("local channel skipped");
    AST_INTEG_LEN: assert property (ce && state == DTC_SET_R && tmr == TMR_ZERO && !abort
        |=> fe_integrate && tmr == TMR_W'(INTEG_CYCLES) - TMR_ONE)
        else $error("integration window wrong");
    AST_START_BUSY: assert property (ce && start && !abort |=> busy && state == DTC_SET_R)
        else $error("start did not raise busy");
    AST_BUSY_END: assert property (ce && state == DTC_LATCH && !abort ##1 ce |=> !busy)
        else $error("busy did not clear after compare");
    AST_NO_PARTIAL: assert property (state != DTC_LATCH |=> $stable(temp_remote) && $stable(temp_local))
        else $error("result changed outside latch");
    AST_ROUND: assert property (ce && state == DTC_LATCH && !abort && raw_r == 9'h00b
        |=> temp_remote == 8'h06)
        else $error("half degree rounding wrong");
    AST_ABORT: assert property (ce && abort |=> state == DTC_IDLE && $stable(temp_remote))
        else $error("abort did not stop conversion");
    AST_ALERT: assert property ((|alarm) |-> ##[0:1] !alert_oe_n)
        else $error("alert not pulled low");
    AST_ALARM_SET: assert property (ce && state == DTC_CMP && cif_l.over |=> alarm[ALM_LHI])
        else $error("local high alarm lost");
    AST_SDA: assert property (ce && sda_pull |=> !sda_oe_n)
        else $error("data line not pulled");

    CVR_FULL: cover property (state == DTC_CMP ##1 state == DTC_IDLE);
    CVR_ABORT: cover property (abort && state == DTC_INT_L);
    CVR_SW_ONESHOT: cover property (sw_stop && oneshot_req && start);
    CVR_ALARM: cover property (|alm_set);
endmodule

// ### dtc_fe_model.sv
`timescale 1ns/1ps
module dtc_fe_model
    import dtc_pkg::*;
(
    // front end controls
    input wire logic fe_local,
    input wire logic fe_integrate,
    // diode temperatures, half-degree steps
    input wire logic signed [RAW_W-1:0] raw_remote,
    input wire logic signed [RAW_W-1:0] raw_local,
    // converter output
    output logic signed [RAW_W-1:0] fe_code
);
    // --------------------------------------------------------------
    // converter
    // --------------------------------------------------------------
    always_comb begin
        if (fe_integrate) begin
            fe_code = fe_local ? raw_local : raw_remote;
        end else begin
            // no valid code outside a window: inverse, so late sampling shows
            fe_code = fe_local ? ~raw_local : ~raw_remote;
        end
    end
endmodule

// ### dual_channel_temp_conversion_control_bench.sv
`timescale 1ns/1ps
module dual_channel_temp_conversion_control_bench;
    import dtc_pkg::*;
    // --------------------------------------------------------------
    // setup
    // --------------------------------------------------------------
    // short counts keep the run brief
    localparam int INTEG_T = 20;
    localparam int SETTLE_T = 5;
    localparam int AUTO_T = 200;
    localparam int CONV_HI = 2 * SETTLE_T + 2 * INTEG_T + 2;
    localparam int LIMIT = 6000;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic a_lo = 1'b0;
    logic a_hi = 1'b0;
    logic hw_sleep_n = 1'b1;
    logic sda_pull = 1'b0;
    logic host_sda = 1'b1;
    logic sw_stop = 1'b1;
    logic [RATE_W-1:0] rate_sel = '0;
    logic oneshot_req = 1'b0;
    logic alarm_clr = 1'b0;
    logic signed [TEMP_W-1:0] th_rh = '0, th_rl = '0, th_lh = '0, th_ll = '0;
    logic signed [RAW_W-1:0] raw_r = '0, raw_l = '0, fe_code;
    logic sda_out, sda_oe_n, alert_out, alert_oe_n, sda_sampled, addr_valid;
    logic fe_local, fe_integrate, busy;
    logic [ADDR_W-1:0] bus_addr;
    logic [ALM_W-1:0] alarm;
    logic signed [TEMP_W-1:0] temp_remote, temp_local, pr, pl;
    logic signed [RAW_W-1:0] corner [8] = '{9'sd11, -9'sd3, 9'sd255, -9'sd256, 9'sd0, -9'sd1, -9'sd2, 9'sd1};
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // data line with pull-up, both ends may pull low
    wire sda_in = (sda_oe_n | sda_out) & host_sda;

    dtc_top #(.INTEG_CYCLES(INTEG_T), .SETTLE_CYCLES(SETTLE_T), .AUTO_CYCLES(AUTO_T)) dtc_top_i (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .addr_select_low_pin(a_lo), .addr_select_high_pin(a_hi), .hw_sleep_n(hw_sleep_n),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .sda_pull(sda_pull), .sda_sampled(sda_sampled), .bus_addr(bus_addr), .addr_valid(addr_valid),
        .sw_stop(sw_stop), .rate_sel(rate_sel), .oneshot_req(oneshot_req), .alarm_clr(alarm_clr),
        .thr_remote_hi(th_rh), .thr_remote_lo(th_rl), .thr_local_hi(th_lh), .thr_local_lo(th_ll),
        .fe_local(fe_local), .fe_integrate(fe_integrate), .fe_code(fe_code),
        .busy(busy), .alarm(alarm), .temp_remote(temp_remote), .temp_local(temp_local)
    );
    dtc_fe_model dtc_fe_model_i (
        .fe_local(fe_local), .fe_integrate(fe_integrate),
        .raw_remote(raw_r), .raw_local(raw_l), .fe_code(fe_code)
    );

    always #25 mclk = ~mclk;

    // --------------------------------------------------------------
    // checking
    // --------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk_bit(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic signed [TEMP_W-1:0] exp_temp(input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W:0] s;
        s = {raw[RAW_W-1], raw};
        s = (s + 10'sd1) >>> 1;
        exp_temp = (s > 10'sd127) ? 8'h7f : s[TEMP_W-1:0];
    endfunction

    // bounded wait for busy to reach a level, ends just after an edge
    task automatic wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge mclk);
            #1;
            if (busy === lvl) break;
        end
    endtask

    task automatic chk_results(input string what);
        logic signed [TEMP_W-1:0] er, el;
        logic [ALM_W-1:0] ea;
        er = exp_temp(raw_r);
        el = exp_temp(raw_l);
        ea = {el < th_ll, el > th_lh, er < th_rl, er > th_rh};
        chk_byte({what, " remote"}, er, temp_remote);
        chk_byte({what, " local"}, el, temp_local);
        chk_byte({what, " alarm"}, {4'h0, ea}, {4'h0, alarm});
        chk_bit({what, " alert"}, ~|ea, alert_oe_n);
    endtask

    // --------------------------------------------------------------
    // one-shot conversion
    // --------------------------------------------------------------
    task automatic run_conv(input logic signed [RAW_W-1:0] rr, input logic signed [RAW_W-1:0] rl);
        int cnt;
        @(posedge mclk);
        raw_r <= rr;
        raw_l <= rl;
        th_rh <= 8'($urandom());
        th_rl <= 8'($urandom());
        th_lh <= 8'($urandom());
        th_ll <= 8'($urandom());
        alarm_clr <= 1'b1;
        @(posedge mclk);
        alarm_clr <= 1'b0;
        @(posedge mclk);
        oneshot_req <= 1'b1;
        #1;
        chk_byte("cleared alarm", 8'h00, {4'h0, alarm});
        chk_bit("cleared alert", 1'b1, alert_oe_n);
        pr = temp_remote;
        pl = temp_local;
        @(posedge mclk);
        oneshot_req <= 1'b0;
        // the taking edge already raises busy, so count it too
        #1;
        cnt = (busy === 1'b1) ? 1 : 0;
        for (int i = 0; i < CONV_HI + 10; i++) begin
            @(posedge mclk);
            #1;
            if (busy === 1'b1) begin
                cnt++;
                if (cnt == CONV_HI / 2) begin
                    chk_byte("mid remote", pr, temp_remote);
                    chk_byte("mid local", pl, temp_local);
                end
            end else if (cnt > 0) begin
                break;
            end
        end
        chk_byte("busy length", 8'(CONV_HI), 8'(cnt));
        chk_results("oneshot");
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(32'hd6218f88));
        a_lo = 1'($urandom());
        a_hi = 1'($urandom());
        repeat (9) @(posedge mclk);
        #1;
        chk_bit("reset busy", 1'b0, busy);
        chk_bit("reset alert", 1'b1, alert_oe_n);
        chk_bit("reset sda", 1'b1, sda_oe_n);
        chk_byte("reset temps", 8'h00, temp_remote | temp_local);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        a_lo <= ~a_lo;
        a_hi <= ~a_hi;
        #1;
        chk_bit("addr valid", 1'b1, addr_valid);
        chk_byte("addr", {6'h00, ~a_hi, ~a_lo}, {6'h00, bus_addr});
        repeat (6) @(posedge mclk);
        #1;
        chk_byte("addr kept", {6'h00, ~a_hi, ~a_lo}, {6'h00, bus_addr});
        // data line, both ends
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            sda_pull <= 1'($urandom());
            host_sda <= 1'($urandom());
            @(posedge mclk);
            #1;
            chk_bit("sda drive", ~sda_pull, sda_oe_n);
            chk_bit("sda level", 1'b0, sda_out | alert_out);
            repeat (2) @(posedge mclk);
            #1;
            chk_bit("sda sampled", host_sda & ~sda_pull, sda_sampled);
        end
        for (int i = 0; i < 4; i++) begin
            run_conv(corner[2*i], corner[2*i+1]);
        end
        for (int i = 0; i < 6; i++) begin
            run_conv(9'($urandom()), 9'($urandom()));
        end
        // hardware standby aborts, keeps data, blocks one-shot
        @(posedge mclk);
        oneshot_req <= 1'b1;
        pr = temp_remote;
        pl = temp_local;
        @(posedge mclk);
        oneshot_req <= 1'b0;
        raw_r <= ~raw_r;
        raw_l <= ~raw_l;
        repeat (30) @(posedge mclk);
        hw_sleep_n <= 1'b0;
        wait_busy(1'b0, 4);
        chk_bit("sleep abort", 1'b0, busy);
        repeat (60) @(posedge mclk);
        oneshot_req <= 1'b1;
        wait_busy(1'b1, 30);
        chk_bit("sleep oneshot", 1'b0, busy);
        chk_byte("sleep remote", pr, temp_remote);
        chk_byte("sleep local", pl, temp_local);
        @(posedge mclk);
        oneshot_req <= 1'b0;
        hw_sleep_n <= 1'b1;
        // sticky alarms from the last one-shot would mask the auto result
        alarm_clr <= 1'b1;
        // free running, then software standby mid-conversion
        @(posedge mclk);
        rate_sel <= 3'($urandom());
        sw_stop <= 1'b0;
        alarm_clr <= 1'b0;
        wait_busy(1'b1, AUTO_T + 10);
        chk_bit("auto start", 1'b1, busy);
        wait_busy(1'b0, CONV_HI + 5);
        chk_results("auto");
        @(posedge mclk);
        raw_r <= 9'($urandom());
        raw_l <= 9'($urandom());
        pr = temp_remote;
        pl = temp_local;
        wait_busy(1'b1, AUTO_T + 10);
        chk_bit("auto again", 1'b1, busy);
        // clock enable low freezes the run well past a full conversion
        @(posedge mclk);
        ce <= 1'b0;
        repeat (3 * CONV_HI) @(posedge mclk);
        #1;
        chk_bit("ce freeze busy", 1'b1, busy);
        chk_byte("ce freeze remote", pr, temp_remote);
        @(posedge mclk);
        ce <= 1'b1;
        repeat (20) @(posedge mclk);
        sw_stop <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk_bit("stop abort", 1'b0, busy);
        chk_byte("stop remote", pr, temp_remote);
        chk_byte("stop local", pl, temp_local);
        complete_run();
    end
endmodule
